/* File: inc/clk_synth_pkg.sv */
// shared constants and types for the clock synthesizer control logic
package clk_synth_pkg;
	localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hD2;
	localparam int CMD_BYTE_MODE_BIT = 7;
	localparam logic [2:0] CMD_BYTE_PREFIX = 3'h4;
	localparam int NUM_CFG_BYTES = 8;
	localparam logic [4:0] LAST_CFG_INDEX = 5'h07;
	localparam logic [7:0] BLOCK_BYTE_COUNT = 8'h08;
	localparam logic [7:0] CFG0_RESET = 8'h40;
	localparam logic [7:0] CFG1_RESET = 8'hFF;
	localparam logic [7:0] CFG2_RESET = 8'h00;
	localparam logic [7:0] CFG3_RESET = 8'hFF;
	localparam logic [7:0] CFG4_RESET = 8'h47;
	localparam logic [7:0] CFG5_RESET = 8'hDF;
	localparam logic [7:0] CFG6_RESET = 8'h03;
	// identity byte: arbitrary neutral value
	localparam logic [7:0] ID_BYTE_VALUE = 8'h11;
	localparam logic [4:0] IDX_STATUS = 5'h00;
	localparam logic [4:0] IDX_OUT_SEL = 5'h05;
	localparam int BIT_OUT_SEL_66_48 = 5;
	localparam logic [4:0] IDX_FREQ_CFG = 5'h06;
	localparam int BIT_ALT_DECODE = 5;
	localparam int BIT_SRC_RATE = 4;
	localparam logic [4:0] IDX_ID = 5'h07;
	localparam logic [7:0] BYTE0_WRITABLE = 8'hF0;
	localparam logic [3:0] BIT_CNT_LAST = 4'h7;
	localparam logic [2:0] CPU_100 = 3'h0;
	localparam logic [2:0] CPU_200 = 3'h1;
	localparam logic [2:0] CPU_133 = 3'h2;
	localparam logic [2:0] CPU_400 = 3'h3;
	localparam logic [2:0] CPU_266 = 3'h4;
	localparam logic [2:0] CPU_RESVD = 3'h7;
	typedef enum logic [1:0] {
		LVL_LOW = 2'h0,
		LVL_HIGH = 2'h1,
		LVL_MID = 2'h2
	} tri_level_t;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_CMD = 7'h04,
		ST_COUNT = 7'h08,
		ST_WDATA = 7'h10,
		ST_RDATA = 7'h20,
		ST_ACK = 7'h40
	} smb_state_t;
endpackage : clk_synth_pkg

/* File: hw/pin_sync.sv */
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} sync_state_t;
	sync_state_t s_q;
	sync_state_t s_d;
	always_comb begin
		s_d.meta = pin_i;
		s_d.sync = s_q.meta;
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			// reset to the idle high level, so no false low strobe or bus edge follows reset
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end
	assign sync_o = s_q.sync;
endmodule : pin_sync

/* File: hw/freq_latch.sv */
// one-shot strap latch for the frequency-select inputs
`timescale 1ns/1ps
module freq_latch
	import clk_synth_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic supply_good_strobe_n_i,
	input wire logic freq_select_first_i,
	input wire logic [1:0] freq_select_second_i,
	output logic latched_o,
	output logic test_mode_o,
	output logic [1:0] straps_o
);
	typedef struct packed {
		logic latched;
		logic test_mode;
		logic [1:0] straps;
	} latch_state_t;
	latch_state_t s_q;
	latch_state_t s_d;
	always_comb begin
		s_d = s_q;
		// capture once on the first low sample, later edges ignored; see RULE12 see RULE13
		if (!s_q.latched && !supply_good_strobe_n_i) begin
			s_d.latched = 1'b1;
			s_d.straps[0] = freq_select_first_i;
			s_d.straps[1] = (freq_select_second_i == LVL_HIGH);
			// mid level enters test mode, left only by reset; see RULE14 see RULE16
			s_d.test_mode = (freq_select_second_i == LVL_MID);
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign latched_o = s_q.latched;
	assign test_mode_o = s_q.test_mode;
	assign straps_o = s_q.straps;
endmodule : freq_latch

/* File: hw/clock_synth_ctrl.sv */
// two-wire slave, configuration bytes and frequency decode of the clock synthesizer
`timescale 1ns/1ps
//
// Summary of operation
// RULE1 - answer only address byte D2h, ignore other addresses
// RULE2 - command bit 7 picks block (0) or single byte (1) access
// RULE3 - low seven command bits give the byte offset; zero for block
// RULE4 - byte commands 100xxxxx use bits 4:0 as the byte index
// RULE5 - block transfers walk upward from index zero, MSB first, stop anywhere
// RULE6 - block write: ack address, command, count and every data byte
// RULE7 - block read: repeated start, read address, count then data bytes
// RULE8 - byte write: ack address, command and one data byte, then stop
// RULE9 - byte read: repeated start, read address, one indexed byte returned
// RULE10 - every configuration byte loads its default at reset
// RULE11 - host uses the serial port only at system start-up
// RULE12 - straps captured on the first low sample of the supply-good strobe
// RULE13 - without mid level the latch is one-shot, later changes ignored
// RULE14 - mid level on second select enters test clock mode
// RULE15 - in test mode first select picks divided reference or high impedance
// RULE16 - test mode exits only through reset with a valid second select
// RULE17 - normal decode: 00 100, 01 200, 10 133 MHz
// RULE18 - byte 6 bit 5 set doubles decode: 200, 400, 266 MHz
// RULE19 - byte 5 bit 5 selects 66 or 48 MHz on fifth fixed output
// RULE20 - byte 0 bits 1:0 read back the captured select levels
// RULE21 - byte 6 bit 5 resets to zero for normal decoding
// RULE22 - byte 6 bit 4 picks serial reference 100 or 200 MHz
// RULE23 - unimplemented offsets read zero, writes acknowledged and dropped
// RULE24 - a stop mid-byte returns to idle keeping completed bytes only
module clock_synth_ctrl
	import clk_synth_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic supply_good_strobe_n_i,
	input wire logic freq_select_first_i,
	input wire logic [1:0] freq_select_second_i,
	output logic [2:0] cpu_rate_o,
	output logic serial_reference_clock_200_o,
	output logic fixed_rate_out_sel_66_48_o,
	output logic test_mode_o,
	output logic test_ref_div_o,
	output logic test_hi_z_o,
	output logic [7:0] byte1_o,
	output logic [7:0] byte2_o,
	output logic [7:0] byte3_o,
	output logic [7:0] byte4_o
);
	typedef struct packed {
		smb_state_t state;
		smb_state_t after_ack;
		logic [1:0] scl_hist;
		logic [1:0] sda_hist;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic is_read;
		logic byte_mode;
		logic [4:0] index;
		logic ack_from_master;
		logic sda_drive;
		logic [NUM_CFG_BYTES-1:0][7:0] cfg;
		logic [2:0] cpu_rate;
		logic src_200;
		logic sel_48;
		logic tmode;
		logic tdiv;
		logic thiz;
	} ctrl_state_t;
	ctrl_state_t s_q;
	ctrl_state_t s_d;
	logic [3:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic strobe_n_s;
	logic first_s;
	logic [1:0] second_s;
	logic latched;
	logic tmode_now;
	logic [1:0] straps;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rd_byte;
	pin_sync #(.WIDTH(4)) u_bus_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pin_i({scl_i, sda_i, supply_good_strobe_n_i, freq_select_first_i}),
		.sync_o(pins_sync)
	);
	pin_sync #(.WIDTH(2)) u_sel_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.pin_i(freq_select_second_i),
		.sync_o(second_s)
	);
	assign {scl_s, sda_s, strobe_n_s, first_s} = pins_sync;
	freq_latch u_latch (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.supply_good_strobe_n_i(strobe_n_s),
		.freq_select_first_i(first_s),
		.freq_select_second_i(second_s),
		.latched_o(latched),
		.test_mode_o(tmode_now),
		.straps_o(straps)
	);
	// byte read-out; unimplemented offsets return zero
	function automatic logic [7:0] read_byte(input logic [4:0] idx, input ctrl_state_t st,
			input logic [1:0] fs);
		logic [7:0] v;
		v = 8'h00; // see RULE23
		if (idx == IDX_STATUS) begin
			v = {st.cfg[0][7:2], fs}; // see RULE20
		end else if (idx == IDX_ID) begin
			v = ID_BYTE_VALUE;
		end else if (idx < LAST_CFG_INDEX) begin
			v = st.cfg[idx[2:0]];
		end
		return v;
	endfunction : read_byte
	function automatic logic [2:0] cpu_decode(input logic [1:0] fs, input logic alt);
		logic [2:0] r;
		case (fs)
			2'b00: r = alt ? CPU_200 : CPU_100;
			2'b10: r = alt ? CPU_400 : CPU_200;
			2'b01: r = alt ? CPU_266 : CPU_133;
			default: r = CPU_RESVD;
		endcase
		return r;
	endfunction : cpu_decode
	assign rd_byte = read_byte(s_q.index, s_q, straps);
	assign scl_rise = (s_q.scl_hist == 2'b01);
	assign scl_fall = (s_q.scl_hist == 2'b10);
	assign start_cond = s_q.scl_hist[1] && scl_s && (s_q.sda_hist == 2'b10);
	assign stop_cond = s_q.scl_hist[1] && scl_s && (s_q.sda_hist == 2'b01);
	always_comb begin
		s_d = s_q;
		s_d.scl_hist = {s_q.scl_hist[0], scl_s};
		s_d.sda_hist = {s_q.sda_hist[0], sda_s};
		if (stop_cond) begin
			// partial byte is dropped, only completed bytes were stored; see RULE24
			s_d.state = ST_IDLE;
			s_d.sda_drive = 1'b0;
		end else if (start_cond) begin
			s_d.state = ST_ADDR; // repeated start too; see RULE7 see RULE9
			s_d.bit_cnt = 4'h0;
			s_d.sda_drive = 1'b0;
		end else if (scl_rise && s_q.state != ST_IDLE && s_q.state != ST_ACK
				&& s_q.state != ST_RDATA) begin
			// while sending, the shifter only moves on falling edges
			s_d.shift = {s_q.shift[6:0], s_q.sda_hist[0]}; // msb first; see RULE5
			s_d.bit_cnt = s_q.bit_cnt + 4'h1;
		end else if (scl_rise && s_q.state == ST_ACK) begin
			s_d.ack_from_master = !s_q.sda_hist[0];
		end else if (scl_fall) begin
			case (s_q.state)
				ST_ADDR, ST_CMD, ST_COUNT, ST_WDATA: begin
					if (s_q.bit_cnt == BIT_CNT_LAST + 4'h1) begin
						s_d.bit_cnt = 4'h0;
						s_d.state = ST_ACK;
						s_d.sda_drive = 1'b1;
						s_d.after_ack = ST_WDATA;
						if (s_q.state == ST_ADDR) begin
							// see RULE1
							if (s_q.shift[7:1] != SLAVE_ADDR_BYTE[7:1]) begin
								s_d.state = ST_IDLE;
								s_d.sda_drive = 1'b0;
							end
							s_d.is_read = s_q.shift[0];
							s_d.after_ack = s_q.shift[0] ? (s_q.byte_mode ? ST_RDATA : ST_COUNT)
								: ST_CMD;
						end else if (s_q.state == ST_CMD) begin
							s_d.byte_mode = s_q.shift[CMD_BYTE_MODE_BIT]; // see RULE2
							// byte index from bits 4:0, block starts at zero; see RULE3 see RULE4
							s_d.index = s_q.shift[CMD_BYTE_MODE_BIT] ? s_q.shift[4:0] : 5'h00;
							s_d.after_ack = s_q.shift[CMD_BYTE_MODE_BIT] ? ST_WDATA : ST_COUNT;
						end else if (s_q.state == ST_COUNT) begin
							s_d.after_ack = ST_WDATA; // count acked then data; see RULE6
						end else begin
							// store and ack the byte; see RULE6 see RULE8 see RULE23
							if (s_q.index == IDX_STATUS) begin
								s_d.cfg[0] = (s_q.cfg[0] & ~BYTE0_WRITABLE)
									| (s_q.shift & BYTE0_WRITABLE);
							end else if (s_q.index < LAST_CFG_INDEX) begin
								s_d.cfg[s_q.index[2:0]] = s_q.shift;
							end
							s_d.index = s_q.index + 5'h01; // see RULE5
						end
					end
				end
				ST_RDATA: begin
					if (s_q.bit_cnt == BIT_CNT_LAST + 4'h1) begin
						s_d.bit_cnt = 4'h0;
						s_d.state = ST_ACK;
						s_d.sda_drive = 1'b0;
						s_d.after_ack = ST_RDATA;
						s_d.index = s_q.index + 5'h01;
					end else begin
						s_d.shift = {s_q.shift[6:0], 1'b0};
						s_d.sda_drive = !s_q.shift[7];
						s_d.bit_cnt = s_q.bit_cnt + 4'h1;
					end
				end
				ST_ACK: begin
					s_d.state = s_q.after_ack;
					s_d.sda_drive = 1'b0;
					s_d.bit_cnt = 4'h0;
					if (s_q.is_read) begin
						if (s_q.after_ack == ST_COUNT) begin
							// block read: count first, then bytes from zero; see RULE7
							s_d.state = ST_RDATA;
							s_d.shift = {BLOCK_BYTE_COUNT[6:0], 1'b0};
							s_d.sda_drive = !BLOCK_BYTE_COUNT[7];
							s_d.bit_cnt = 4'h1;
							s_d.index = 5'h1F;
						end else if (s_q.sda_drive || s_q.ack_from_master) begin
							s_d.state = ST_RDATA; // see RULE9
							s_d.shift = {rd_byte[6:0], 1'b0};
							s_d.sda_drive = !rd_byte[7];
							s_d.bit_cnt = 4'h1;
						end else begin
							s_d.state = ST_IDLE;
						end
					end
				end
				default: begin
					s_d.state = s_q.state;
				end
			endcase
		end
		// strap-driven rate decode; see RULE17 see RULE18 see RULE21
		s_d.cpu_rate = cpu_decode(straps, s_q.cfg[IDX_FREQ_CFG[2:0]][BIT_ALT_DECODE]);
		s_d.src_200 = s_q.cfg[IDX_FREQ_CFG[2:0]][BIT_SRC_RATE]; // see RULE22
		s_d.sel_48 = s_q.cfg[IDX_OUT_SEL[2:0]][BIT_OUT_SEL_66_48]; // see RULE19
		s_d.tmode = tmode_now;
		// first select follows live in test mode, not the captured value; see RULE15
		s_d.tdiv = tmode_now && !first_s;
		s_d.thiz = tmode_now && first_s;
		if (!latched) begin
			s_d.cpu_rate = CPU_100;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q.state <= ST_IDLE;
			s_q.after_ack <= ST_IDLE;
			s_q.scl_hist <= 2'b11;
			s_q.sda_hist <= 2'b11;
			s_q.bit_cnt <= 4'h0;
			s_q.shift <= 8'h00;
			s_q.is_read <= 1'b0;
			s_q.byte_mode <= 1'b0;
			s_q.index <= 5'h00;
			s_q.ack_from_master <= 1'b0;
			s_q.sda_drive <= 1'b0;
			// defaults make the part usable with no serial access; see RULE10
			s_q.cfg[0] <= CFG0_RESET;
			s_q.cfg[1] <= CFG1_RESET;
			s_q.cfg[2] <= CFG2_RESET;
			s_q.cfg[3] <= CFG3_RESET;
			s_q.cfg[4] <= CFG4_RESET;
			s_q.cfg[5] <= CFG5_RESET;
			s_q.cfg[6] <= CFG6_RESET;
			s_q.cfg[7] <= ID_BYTE_VALUE;
			s_q.cpu_rate <= CPU_100;
			s_q.src_200 <= 1'b0;
			s_q.sel_48 <= 1'b0;
			s_q.tmode <= 1'b0;
			s_q.tdiv <= 1'b0;
			s_q.thiz <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end
	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_o = s_q.sda_drive;
	assign cpu_rate_o = s_q.cpu_rate;
	assign serial_reference_clock_200_o = s_q.src_200;
	assign fixed_rate_out_sel_66_48_o = s_q.sel_48;
	assign test_mode_o = s_q.tmode;
	assign test_ref_div_o = s_q.tdiv;
	assign test_hi_z_o = s_q.thiz;
	assign byte1_o = s_q.cfg[1];
	assign byte2_o = s_q.cfg[2];
	assign byte3_o = s_q.cfg[3];
	assign byte4_o = s_q.cfg[4];
endmodule : clock_synth_ctrl

/* File: bench/clock_synth_ctrl_assertions.sv */
// port-level checks for the synthesizer control block
`timescale 1ns/1ps
module clock_synth_ctrl_chk
	import clk_synth_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic freq_select_first_i,
	input wire logic [1:0] freq_select_second_i,
	input wire logic [2:0] cpu_rate_o,
	input wire logic test_mode_o,
	input wire logic test_ref_div_o,
	input wire logic test_hi_z_o,
	input wire logic [7:0] byte1_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// data may only move well inside the low phase of the bus clock
	sequence low_hold;
		!scl_i [*5];
	endsequence
	sequence high_run;
		scl_i [*4];
	endsequence
	sequence steady_hi_sel;
		(test_mode_o && freq_select_first_i) [*5];
	endsequence
	sequence steady_lo_sel;
		(test_mode_o && !freq_select_first_i) [*5];
	endsequence
	AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
		else $error("data output not tied low");
	AST_OE_IN_LOW: assert property ($changed(sda_oe_o) |-> low_hold)
		else $error("data drive moved near a high clock phase");
	AST_OE_STABLE_HIGH: assert property (high_run |-> $stable(sda_oe_o))
		else $error("data drive changed while clock high");
	AST_RESET_QUIET: assert property ($fell(rst_i) |-> !sda_oe_o && !test_mode_o
		&& cpu_rate_o == CPU_100 && byte1_o == CFG1_RESET)
		else $error("outputs not at defaults after reset");
	AST_TEST_STICKY: assert property (test_mode_o |=> test_mode_o)
		else $error("test clock mode left without reset");
	AST_TEST_ENTRY: assert property ($rose(test_mode_o) |-> freq_select_second_i == LVL_MID)
		else $error("test clock mode entered without mid level");
	AST_HIZ_SEL: assert property (steady_hi_sel |-> test_hi_z_o && !test_ref_div_o)
		else $error("high impedance not selected");
	AST_REFDIV_SEL: assert property (steady_lo_sel |-> test_ref_div_o && !test_hi_z_o)
		else $error("divided reference not selected");
	AST_NORMAL_QUIET: assert property (!test_mode_o |-> !test_hi_z_o && !test_ref_div_o)
		else $error("test output choice active in normal mode");
endmodule : clock_synth_ctrl_chk

/* File: bench/smb_host.sv */
// behavioural two-wire bus host for the bench
`timescale 1ns/1ps
module smb_host (
	input wire logic ref_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_pull_o
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : tick
	// data moves a few cycles after the clock fall, never with it
	task automatic bit_io(input logic b, output logic s);
		tick(4);
		sda_pull_o = ~b;
		tick(12);
		scl_o = 1'b1;
		tick(8);
		s = sda_i;
		tick(8);
		scl_o = 1'b0;
	endtask : bit_io
	task automatic start();
		tick(4);
		sda_pull_o = 1'b0;
		tick(12);
		scl_o = 1'b1;
		tick(16);
		sda_pull_o = 1'b1;
		tick(16);
		scl_o = 1'b0;
	endtask : start
	task automatic stop();
		tick(4);
		sda_pull_o = 1'b1;
		tick(12);
		scl_o = 1'b1;
		tick(16);
		sda_pull_o = 1'b0;
		tick(16);
	endtask : stop
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : put
	task automatic get(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(nack, s);
	endtask : get
endmodule : smb_host

/* File: bench/clock_synth_smbus_and_freq_latch_test.sv */
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module clock_synth_smbus_and_freq_latch_test
	import clk_synth_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic strobe_n = 1'b1;
	logic fsa = 1'b0;
	logic [1:0] fsb = LVL_LOW;
	logic scl, pull, sda_drv, sda_oe, test_mode, ref_div, hi_z, ref200, sel48;
	logic [2:0] cpu, a;
	logic [7:0] b1, b2, b3, b4, v;
	int n_errors = 0;
	int comparisons = 0;
	// pulled-up wire: low while either side pulls
	wire logic sda = ~(pull | (sda_oe & ~sda_drv));
	wire logic [7:0] st = {hi_z, ref_div, test_mode, sel48, ref200, cpu};
	wire logic [31:0] cfg = {b4, b3, b2, b1};
	logic [2:0] norm [3] = '{CPU_100, CPU_200, CPU_133};
	logic [2:0] alt [3] = '{CPU_200, CPU_400, CPU_266};
	logic [7:0] blk [8] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hFF, 8'h10, ID_BYTE_VALUE};
	clock_synth_ctrl dut (.ref_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_drv), .sda_oe_o(sda_oe), .supply_good_strobe_n_i(strobe_n),
		.freq_select_first_i(fsa), .freq_select_second_i(fsb), .cpu_rate_o(cpu),
		.serial_reference_clock_200_o(ref200), .fixed_rate_out_sel_66_48_o(sel48),
		.test_mode_o(test_mode), .test_ref_div_o(ref_div), .test_hi_z_o(hi_z),
		.byte1_o(b1), .byte2_o(b2), .byte3_o(b3), .byte4_o(b4));
	smb_host host (.ref_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic strobe(input int n);
		repeat (n) @(negedge clk);
		strobe_n = 1'b0;
		repeat (8) @(negedge clk);
	endtask : strobe
	task automatic power_up(input logic fa, input logic [1:0] fb);
		@(negedge clk);
		rst = 1'b1;
		strobe_n = 1'b1;
		fsa = fa;
		fsb = fb;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		strobe(8);
	endtask : power_up
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		host.start();
		host.put(SLAVE_ADDR_BYTE, a[2]);
		host.put(cmd, a[1]);
		host.put(d, a[0]);
		host.stop();
		chk("write acks", {5'h0, a}, 8'h07);
	endtask : wr
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		host.start();
		host.put(SLAVE_ADDR_BYTE, a[2]);
		host.put(cmd, a[1]);
		host.start();
		host.put(SLAVE_ADDR_BYTE | 8'h01, a[0]);
		host.get(v, 1'b1);
		host.stop();
		chk("read acks", {5'h0, a}, 8'h07);
		chk("read byte", v, exp);
	endtask : rd
	initial begin
		for (int p = 0; p < 3; p++) begin
			power_up(p[1], p[0] ? LVL_HIGH : LVL_LOW);
			chk("rate", st, {5'h0, norm[p]});
			rd(8'h80, {CFG0_RESET[7:2], p[0], p[1]});
			fsa = ~fsa;
			fsb = LVL_MID;
			strobe_n = 1'b1;
			strobe(8);
			chk("one shot", st, {5'h0, norm[p]});
			wr(8'h86, 8'h20);
			chk("alt rate", st, {5'h0, alt[p]});
		end
		$display("test select decode finished");
		power_up(1'b0, LVL_LOW);
		chk("byte1", b1, CFG1_RESET);
		chk("byte2", b2, CFG2_RESET);
		chk("byte3", b3, CFG3_RESET);
		chk("byte4", b4, CFG4_RESET);
		rd(8'h86, CFG6_RESET);
		rd(8'h85, CFG5_RESET);
		wr(8'h86, 8'h10);
		wr(8'h85, CFG5_RESET | 8'h20);
		chk("clock selects", st, 8'h18);
		for (int i = 1; i < 5; i++) begin
			wr(8'h80 | 8'(i), 8'hA0 + 8'(i));
			chk("cfg byte", cfg[8*i-8 +: 8], 8'hA0 + 8'(i));
			rd(8'h80 | 8'(i), 8'hA0 + 8'(i));
		end
		wr(8'h9F, 8'h5A);
		rd(8'h9F, 8'h00);
		wr(8'h87, 8'h00);
		rd(8'h87, ID_BYTE_VALUE);
		wr(8'h80, 8'hFF);
		rd(8'h80, 8'hF0);
		host.start();
		host.put(8'hD4, a[0]);
		host.put(8'h81, a[1]);
		host.put(8'h00, a[2]);
		host.stop();
		chk("foreign acks", {5'h0, a}, 8'h00);
		chk("byte1 kept", b1, 8'hA1);
		host.start();
		host.put(SLAVE_ADDR_BYTE, a[0]);
		host.put(8'h82, a[1]);
		for (int k = 0; k < 4; k++) host.bit_io(1'b0, a[2]);
		host.stop();
		chk("partial byte", b2, 8'hA2);
		wr(8'h83, 8'h3C);
		chk("after abort", b3, 8'h3C);
		$display("test byte access finished");
		host.start();
		host.put(SLAVE_ADDR_BYTE, a[2]);
		host.put(8'h00, a[1]);
		host.put(8'h05, a[0]);
		chk("block acks", {5'h0, a}, 8'h07);
		for (int i = 0; i < 5; i++) begin
			host.put(8'hC0 + 8'(i), a[0]);
			chk("data ack", {7'h0, a[0]}, 8'h01);
		end
		host.stop();
		for (int i = 1; i < 5; i++) chk("block byte", cfg[8*i-8 +: 8], blk[i]);
		host.start();
		host.put(SLAVE_ADDR_BYTE, a[2]);
		host.put(8'h00, a[1]);
		host.start();
		host.put(SLAVE_ADDR_BYTE | 8'h01, a[0]);
		chk("block read acks", {5'h0, a}, 8'h07);
		host.get(v, 1'b0);
		chk("count", v, BLOCK_BYTE_COUNT);
		for (int i = 0; i < 8; i++) begin
			host.get(v, i == 7);
			chk("block read", v, blk[i]);
		end
		host.stop();
		$display("test block access finished");
		power_up(1'b0, LVL_MID);
		chk("test ref", {st[7:3], 3'h0}, 8'h60);
		fsa = 1'b1;
		repeat (8) @(negedge clk);
		chk("test hiz", {st[7:3], 3'h0}, 8'hA0);
		fsb = LVL_LOW;
		strobe_n = 1'b1;
		strobe(8);
		chk("test held", {st[7:3], 3'h0}, 8'hA0);
		power_up(1'b0, LVL_HIGH);
		chk("test exit", st, {5'h0, CPU_200});
		$display("test clock mode finished");
		tally_and_finish();
	end
	// about two and a half times the expected run length
	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule : clock_synth_smbus_and_freq_latch_test
bind clock_synth_ctrl clock_synth_ctrl_chk chk (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.freq_select_first_i(freq_select_first_i),
	.freq_select_second_i(freq_select_second_i),
	.cpu_rate_o(cpu_rate_o),
	.test_mode_o(test_mode_o),
	.test_ref_div_o(test_ref_div_o),
	.test_hi_z_o(test_hi_z_o),
	.byte1_o(byte1_o)
);
